// ==== cif_irq_top.sv ====
module cif_irq_top (
	// Clock and reset
	input wire logic clk_in,
	input wire logic reset_in,
	// Avalon-MM slave
	input wire logic [3:0] avs_address_in,
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic [31:0] avs_writedata_in,
	input wire logic [3:0] avs_byteenable_in,
	output logic [31:0] avs_readdata_out,
	output logic avs_waitrequest_out,
	// Event pulses from the controller core, same clock
	input wire logic [8:0] event_in,
	// Interrupt request and module state
	output logic irq_out,
	output logic module_on_out
);
	cif_pkg::cif_irq_s irq_w;
	logic [8:0] flag_w;
	logic [8:0] en_r;
	logic [8:0] clear_w;
	logic module_on_r;
	logic off_on_w;
	logic seen_off_r;
	logic ack_r;
	logic [31:0] rdata_r;
	logic [31:0] wmask_w;
	logic [31:0] irq_word_w;
	logic [31:0] wr_irq_w;
	logic [31:0] wr_ctrl_w;
	logic req_w;
	logic irq_req_r;

	// Source order: 8=bad msg,7=wake,6=bus err,5=sys err,4=rx ovf,3=mode,2=stamp,1=rx,0=tx
	function automatic logic [31:0] cif_pack(input logic [8:0] en, input logic [8:0] fl);
		cif_pack = {en[8:4], 7'h00, en[3:0], fl[8:4], 7'h00, fl[3:0]};
	endfunction : cif_pack

	function automatic logic [31:0] cif_merge(input logic [31:0] old, input logic [31:0] wd,
		input logic [31:0] m);
		cif_merge = (old & ~m) | (wd & m);
	endfunction : cif_merge

	function automatic logic [8:0] cif_en_of(input logic [31:0] w);
		cif_en_of = {w[31:27], w[19:16]};
	endfunction : cif_en_of

	function automatic logic [8:0] cif_fl_of(input logic [31:0] w);
		cif_fl_of = {w[15:11], w[3:0]};
	endfunction : cif_fl_of

	// ************************************************************
	// Bus slave
	// ************************************************************
	// One wait cycle per access keeps the read data registered
	assign avs_waitrequest_out = (avs_read_in | avs_write_in) & ~ack_r;

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			ack_r <= 1'b0;
		end else begin
			ack_r <= (avs_read_in | avs_write_in) & ~ack_r;
		end
	end

	assign wmask_w = {{8{avs_byteenable_in[3]}}, {8{avs_byteenable_in[2]}},
		{8{avs_byteenable_in[1]}}, {8{avs_byteenable_in[0]}}};
	assign irq_word_w = cif_pack(en_r, flag_w);
	assign wr_irq_w = cif_merge(irq_word_w, avs_writedata_in, wmask_w) & cif_pkg::CIF_IRQ_MASK;
	assign wr_ctrl_w = cif_merge({16'h0000, module_on_r, 15'h0000}, avs_writedata_in, wmask_w);

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			rdata_r <= cif_pkg::CIF_RESET_VALUE;
		end else if (avs_read_in & ~ack_r) begin
			case (avs_address_in)
				cif_pkg::CIF_OFS_IRQ: rdata_r <= irq_word_w & cif_pkg::CIF_IRQ_MASK;
				cif_pkg::CIF_OFS_CTRL: rdata_r <= {16'h0000, module_on_r, 15'h0000};
				default: rdata_r <= 32'h0000_0000;
			endcase
		end
	end
	assign avs_readdata_out = rdata_r;

	// ************************************************************
	// Enables and module on bit
	// ************************************************************
	logic wr_take_w;
	assign wr_take_w = avs_write_in & ~ack_r;

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			en_r <= '0;
		end else if (wr_take_w && avs_address_in == cif_pkg::CIF_OFS_IRQ) begin
			en_r <= cif_en_of(wr_irq_w);
		end
	end

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			module_on_r <= 1'b0;
		end else if (wr_take_w && avs_address_in == cif_pkg::CIF_OFS_CTRL) begin
			module_on_r <= wr_ctrl_w[cif_pkg::CIF_MODULE_ON_POS];
		end
	end

	// Off seen since last on; a rising on after an off clears system error
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			seen_off_r <= 1'b0;
		end else if (off_on_w) begin
			seen_off_r <= 1'b0;
		end else if (!module_on_r) begin
			seen_off_r <= 1'b1;
		end
	end

	assign off_on_w = wr_take_w && avs_address_in == cif_pkg::CIF_OFS_CTRL &&
		wr_ctrl_w[cif_pkg::CIF_MODULE_ON_POS] && !module_on_r && seen_off_r;
	assign module_on_out = module_on_r;

	// ************************************************************
	// Flags
	// ************************************************************
	// Writing zero clears a flag; system error is excluded inside the bank
	assign clear_w = (wr_take_w && avs_address_in == cif_pkg::CIF_OFS_IRQ) ?
		(flag_w & ~cif_fl_of(wr_irq_w)) : 9'h000;

	cif_flag_bank u_flags (
		.clk_in(clk_in),
		.reset_in(reset_in),
		.event_in(event_in),
		.clear_in(clear_w),
		.off_on_in(off_on_w),
		.flag_out(flag_w)
	);

	always_comb begin
		irq_w.en = en_r;
		irq_w.flag = flag_w;
	end

	// ************************************************************
	// Interrupt request
	// ************************************************************
	assign req_w = |(irq_w.en & irq_w.flag);

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			irq_req_r <= 1'b0;
		end else begin
			irq_req_r <= req_w;
		end
	end
	assign irq_out = irq_req_r;

	// ************************************************************
	// Checks
	// ************************************************************
	sequence s_off_write;
		wr_take_w && avs_address_in == cif_pkg::CIF_OFS_CTRL &&
			!wr_ctrl_w[cif_pkg::CIF_MODULE_ON_POS];
	endsequence

	sequence s_on_write;
		off_on_w && !event_in[cif_pkg::CIF_SYS_ERR_IDX];
	endsequence

	sequence s_irq_write;
		wr_take_w && avs_address_in == cif_pkg::CIF_OFS_IRQ;
	endsequence

	// ************************************************************
	// Reset and bus
	// ************************************************************
	chk_reset_clear: assert property (@(posedge clk_in)
		reset_in |=> en_r == 9'h000 && flag_w == 9'h000 && !irq_out && !module_on_out)
		else $error("state not cleared by reset");
	chk_unused_zero: assert property (@(posedge clk_in) disable iff (reset_in)
		(avs_readdata_out & ~cif_pkg::CIF_IRQ_MASK) == 32'h0000_0000)
		else $error("unimplemented bits not zero");
	chk_unmapped_write: assert property (@(posedge clk_in) disable iff (reset_in)
		wr_take_w && avs_address_in != cif_pkg::CIF_OFS_IRQ &&
		avs_address_in != cif_pkg::CIF_OFS_CTRL |=> en_r == $past(en_r) &&
		module_on_r == $past(module_on_r))
		else $error("write to unmapped offset changed state");
	chk_wait_one: assert property (@(posedge clk_in) disable iff (reset_in)
		$rose(avs_read_in) |=> !avs_waitrequest_out)
		else $error("read not answered after one wait cycle");

	// ************************************************************
	// Interrupt gating
	// ************************************************************
	chk_irq_gate_any: assert property (@(posedge clk_in) disable iff (reset_in)
		irq_out == $past(|(en_r & flag_w)))
		else $error("interrupt output not equal to gated flags");
	chk_bad_msg_pass: assert property (@(posedge clk_in) disable iff (reset_in)
		en_r[8] && flag_w[8] |=> irq_out)
		else $error("bad message request blocked while enabled");
	chk_bad_msg_gate: assert property (@(posedge clk_in) disable iff (reset_in)
		!en_r[8] && (en_r[7:0] & flag_w[7:0]) == 8'h00 |=> !irq_out)
		else $error("bad message request passed while disabled");
	chk_wake_gate: assert property (@(posedge clk_in) disable iff (reset_in)
		en_r[7] && flag_w[7] |=> irq_out)
		else $error("wake request blocked while enabled");
	chk_wake_block: assert property (@(posedge clk_in) disable iff (reset_in)
		flag_w[7] && !en_r[7] && (en_r & flag_w) == 9'h000 |=> !irq_out)
		else $error("wake request passed while disabled");
	chk_bus_err_gate: assert property (@(posedge clk_in) disable iff (reset_in)
		en_r[6] && flag_w[6] |=> irq_out)
		else $error("bus error request blocked while enabled");
	chk_bus_err_block: assert property (@(posedge clk_in) disable iff (reset_in)
		flag_w[6] && !en_r[6] && (en_r & flag_w) == 9'h000 |=> !irq_out)
		else $error("bus error request passed while disabled");
	chk_sys_err_gate: assert property (@(posedge clk_in) disable iff (reset_in)
		en_r[5] && flag_w[5] |=> irq_out)
		else $error("system error request blocked while enabled");
	chk_sys_err_block: assert property (@(posedge clk_in) disable iff (reset_in)
		flag_w[5] && !en_r[5] && (en_r & flag_w) == 9'h000 |=> !irq_out)
		else $error("system error request passed while disabled");
	chk_rx_ovf_gate: assert property (@(posedge clk_in) disable iff (reset_in)
		en_r[4] && flag_w[4] |=> irq_out)
		else $error("receive overflow request blocked while enabled");
	chk_rx_ovf_block: assert property (@(posedge clk_in) disable iff (reset_in)
		flag_w[4] && !en_r[4] && (en_r & flag_w) == 9'h000 |=> !irq_out)
		else $error("receive overflow request passed while disabled");
	chk_mode_gate: assert property (@(posedge clk_in) disable iff (reset_in)
		en_r[3] && flag_w[3] |=> irq_out)
		else $error("mode change request blocked while enabled");
	chk_mode_block: assert property (@(posedge clk_in) disable iff (reset_in)
		flag_w[3] && !en_r[3] && (en_r & flag_w) == 9'h000 |=> !irq_out)
		else $error("mode change request passed while disabled");
	chk_stamp_gate: assert property (@(posedge clk_in) disable iff (reset_in)
		en_r[2] && flag_w[2] |=> irq_out)
		else $error("timestamp request blocked while enabled");
	chk_stamp_block: assert property (@(posedge clk_in) disable iff (reset_in)
		flag_w[2] && !en_r[2] && (en_r & flag_w) == 9'h000 |=> !irq_out)
		else $error("timestamp request passed while disabled");
	chk_rx_buf_gate: assert property (@(posedge clk_in) disable iff (reset_in)
		en_r[1] && flag_w[1] |=> irq_out)
		else $error("receive buffer request blocked while enabled");
	chk_rx_buf_block: assert property (@(posedge clk_in) disable iff (reset_in)
		flag_w[1] && !en_r[1] && (en_r & flag_w) == 9'h000 |=> !irq_out)
		else $error("receive buffer request passed while disabled");
	chk_tx_buf_gate: assert property (@(posedge clk_in) disable iff (reset_in)
		en_r[0] && flag_w[0] |=> irq_out)
		else $error("transmit buffer request blocked while enabled");
	chk_tx_buf_block: assert property (@(posedge clk_in) disable iff (reset_in)
		flag_w[0] && !en_r[0] && (en_r & flag_w) == 9'h000 |=> !irq_out)
		else $error("transmit buffer request passed while disabled");

	// ************************************************************
	// Flag setting
	// ************************************************************
	chk_wake_set: assert property (@(posedge clk_in) disable iff (reset_in)
		event_in[7] |=> flag_w[7])
		else $error("wake event not recorded");
	chk_bus_err_set: assert property (@(posedge clk_in) disable iff (reset_in)
		event_in[6] |=> flag_w[6])
		else $error("bus error event not recorded");
	chk_sys_err_set: assert property (@(posedge clk_in) disable iff (reset_in)
		event_in[5] |=> flag_w[5])
		else $error("system error event not recorded");
	chk_rx_ovf_set: assert property (@(posedge clk_in) disable iff (reset_in)
		event_in[4] |=> flag_w[4])
		else $error("receive overflow event not recorded");
	chk_mode_set: assert property (@(posedge clk_in) disable iff (reset_in)
		event_in[3] |=> flag_w[3])
		else $error("mode change event not recorded");
	chk_stamp_set: assert property (@(posedge clk_in) disable iff (reset_in)
		event_in[2] |=> flag_w[2])
		else $error("timestamp event not recorded");
	chk_rx_buf_set: assert property (@(posedge clk_in) disable iff (reset_in)
		event_in[1] |=> flag_w[1])
		else $error("receive buffer event not recorded");
	chk_tx_buf_set: assert property (@(posedge clk_in) disable iff (reset_in)
		event_in[0] |=> flag_w[0])
		else $error("transmit buffer event not recorded");

	// ************************************************************
	// Flag clearing
	// ************************************************************
	chk_bad_msg_clear: assert property (@(posedge clk_in) disable iff (reset_in)
		s_irq_write ##0 (!wr_irq_w[15] && !event_in[8]) |=> !flag_w[8])
		else $error("bad message flag not cleared by zero");
	chk_wake_clear: assert property (@(posedge clk_in) disable iff (reset_in)
		s_irq_write ##0 (!wr_irq_w[14] && !event_in[7]) |=> !flag_w[7])
		else $error("wake flag not cleared by zero");
	chk_bus_err_clear: assert property (@(posedge clk_in) disable iff (reset_in)
		s_irq_write ##0 (!wr_irq_w[13] && !event_in[6]) |=> !flag_w[6])
		else $error("bus error flag not cleared by zero");
	chk_rx_ovf_clear: assert property (@(posedge clk_in) disable iff (reset_in)
		s_irq_write ##0 (!wr_irq_w[11] && !event_in[4]) |=> !flag_w[4])
		else $error("receive overflow flag not cleared by zero");
	chk_mode_clear: assert property (@(posedge clk_in) disable iff (reset_in)
		s_irq_write ##0 (!wr_irq_w[3] && !event_in[3]) |=> !flag_w[3])
		else $error("mode change flag not cleared by zero");
	chk_stamp_clear: assert property (@(posedge clk_in) disable iff (reset_in)
		s_irq_write ##0 (!wr_irq_w[2] && !event_in[2]) |=> !flag_w[2])
		else $error("timestamp flag not cleared by zero");
	chk_rx_buf_clear: assert property (@(posedge clk_in) disable iff (reset_in)
		s_irq_write ##0 (!wr_irq_w[1] && !event_in[1]) |=> !flag_w[1])
		else $error("receive buffer flag not cleared by zero");
	chk_tx_buf_clear: assert property (@(posedge clk_in) disable iff (reset_in)
		s_irq_write ##0 (!wr_irq_w[0] && !event_in[0]) |=> !flag_w[0])
		else $error("transmit buffer flag not cleared by zero");
	chk_sys_err_keep: assert property (@(posedge clk_in) disable iff (reset_in)
		s_irq_write ##0 flag_w[5] |=> flag_w[5])
		else $error("system error flag cleared by software");
	chk_sys_off_on: assert property (@(posedge clk_in) disable iff (reset_in)
		s_off_write ##1 (!module_on_r)[*2] ##[0:20] s_on_write |=> !flag_w[5])
		else $error("system error flag survived off and on");

	// ************************************************************
	// Enable writes, byte lanes honoured
	// ************************************************************
	chk_bad_msg_en_wr: assert property (@(posedge clk_in) disable iff (reset_in)
		s_irq_write ##0 avs_byteenable_in[3] |=> en_r[8] == $past(avs_writedata_in[31]))
		else $error("bad message enable not written");
	chk_wake_en_wr: assert property (@(posedge clk_in) disable iff (reset_in)
		s_irq_write ##0 avs_byteenable_in[3] |=> en_r[7] == $past(avs_writedata_in[30]))
		else $error("wake enable not written");
	chk_bus_err_en_wr: assert property (@(posedge clk_in) disable iff (reset_in)
		s_irq_write ##0 avs_byteenable_in[3] |=> en_r[6] == $past(avs_writedata_in[29]))
		else $error("bus error enable not written");
	chk_sys_err_en_wr: assert property (@(posedge clk_in) disable iff (reset_in)
		s_irq_write ##0 avs_byteenable_in[3] |=> en_r[5] == $past(avs_writedata_in[28]))
		else $error("system error enable not written");
	chk_rx_ovf_en_wr: assert property (@(posedge clk_in) disable iff (reset_in)
		s_irq_write ##0 avs_byteenable_in[3] |=> en_r[4] == $past(avs_writedata_in[27]))
		else $error("receive overflow enable not written");
	chk_mode_en_wr: assert property (@(posedge clk_in) disable iff (reset_in)
		s_irq_write ##0 avs_byteenable_in[2] |=> en_r[3] == $past(avs_writedata_in[19]))
		else $error("mode change enable not written");
	chk_stamp_en_wr: assert property (@(posedge clk_in) disable iff (reset_in)
		s_irq_write ##0 avs_byteenable_in[2] |=> en_r[2] == $past(avs_writedata_in[18]))
		else $error("timestamp enable not written");
	chk_rx_buf_en_wr: assert property (@(posedge clk_in) disable iff (reset_in)
		s_irq_write ##0 avs_byteenable_in[2] |=> en_r[1] == $past(avs_writedata_in[17]))
		else $error("receive buffer enable not written");
	chk_tx_buf_en_wr: assert property (@(posedge clk_in) disable iff (reset_in)
		s_irq_write ##0 avs_byteenable_in[2] |=> en_r[0] == $past(avs_writedata_in[16]))
		else $error("transmit buffer enable not written");
endmodule : cif_irq_top

// ==== cif_pkg.sv ====
package cif_pkg;
	// ************************************************************
	// Register map
	// ************************************************************
	localparam logic [3:0] CIF_OFS_IRQ = 4'h0;
	localparam logic [3:0] CIF_OFS_CTRL = 4'h4;
	localparam logic [3:0] CIF_OFS_EVENT = 4'h8;
	localparam logic [31:0] CIF_RESET_VALUE = 32'h0000_0000;
	localparam int CIF_NSRC = 9;

	// ************************************************************
	// Field positions
	// ************************************************************
	localparam int CIF_BAD_MSG_EN_POS = 31;
	localparam int CIF_WAKE_EN_POS = 30;
	localparam int CIF_BUS_ERR_EN_POS = 29;
	localparam int CIF_SYS_ERR_EN_POS = 28;
	localparam int CIF_RX_OVF_EN_POS = 27;
	localparam int CIF_MODE_EN_POS = 19;
	localparam int CIF_STAMP_EN_POS = 18;
	localparam int CIF_RX_BUF_EN_POS = 17;
	localparam int CIF_TX_BUF_EN_POS = 16;
	localparam int CIF_BAD_MSG_FLAG_POS = 15;
	localparam int CIF_SYS_ERR_FLAG_POS = 12;
	localparam int CIF_MODULE_ON_POS = 15;
	// Source index of system error in the packed source vector
	localparam int CIF_SYS_ERR_IDX = 5;
	// Source index of the invalid message event
	localparam int CIF_BAD_MSG_IDX = 8;
	// Implemented bits of the interrupt register
	localparam logic [31:0] CIF_IRQ_MASK = 32'hf80f_f80f;
	localparam logic [31:0] CIF_CTRL_MASK = 32'h0000_8000;

	typedef struct packed {
		logic [CIF_NSRC-1:0] en;
		logic [CIF_NSRC-1:0] flag;
	} cif_irq_s;
endpackage : cif_pkg

// ==== cif_flag_bank.sv ====
module cif_flag_bank (
	// Clock and reset
	input wire logic clk_in,
	input wire logic reset_in,
	// Events and clears
	input wire logic [8:0] event_in,
	input wire logic [8:0] clear_in,
	input wire logic off_on_in,
	// Flags
	output logic [8:0] flag_out
);
	logic [8:0] flag_r;
	logic [8:0] flag_nxt;

	// ************************************************************
	// Sticky flags, set wins over clear
	// ************************************************************
	always_comb begin
		flag_nxt = flag_r;
		for (int i = 0; i < 9; i++) begin
			if (i == cif_pkg::CIF_SYS_ERR_IDX) begin
				if (off_on_in) begin
					flag_nxt[i] = 1'b0;
				end
			end else if (clear_in[i]) begin
				flag_nxt[i] = 1'b0;
			end
			if (event_in[i]) begin
				flag_nxt[i] = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			flag_r <= '0;
		end else begin
			flag_r <= flag_nxt;
		end
	end

	assign flag_out = flag_r;

	chk_flag_set_sticky: assert property (@(posedge clk_in) disable iff (reset_in)
		event_in[cif_pkg::CIF_BAD_MSG_IDX] |=> flag_r[cif_pkg::CIF_BAD_MSG_IDX])
		else $error("bad message event not recorded");
	chk_sys_clear_only: assert property (@(posedge clk_in) disable iff (reset_in)
		$past(flag_r[cif_pkg::CIF_SYS_ERR_IDX]) && !$past(off_on_in)
		|-> flag_r[cif_pkg::CIF_SYS_ERR_IDX])
		else $error("system error flag cleared without off-on");
endmodule : cif_flag_bank

// ==== tb.sv ====
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	// ************************************************************
	// Stimulus and observed signals
	// ************************************************************
	logic clk_in = 1'b0;
	logic reset_in = 1'b1;
	logic [3:0] avs_address_in = 4'h0;
	logic avs_read_in = 1'b0;
	logic avs_write_in = 1'b0;
	logic [31:0] avs_writedata_in = 32'h0000_0000;
	logic [3:0] avs_byteenable_in = 4'hf;
	logic [8:0] event_in = 9'h000;
	logic [31:0] avs_readdata_out;
	logic avs_waitrequest_out;
	logic irq_out;
	logic module_on_out;
	int failures = 0;
	int check_count = 0;
	int epos[9] = '{16, 17, 18, 19, 27, 28, 29, 30, 31};
	int fpos[9] = '{0, 1, 2, 3, 11, 12, 13, 14, 15};
	// System error last: its flag survives software clears
	int ord[9] = '{0, 1, 2, 3, 4, 6, 7, 8, 5};

	always #10 clk_in = ~clk_in;

	cif_irq_top u_cif_irq_top (
		.clk_in(clk_in),
		.reset_in(reset_in),
		.avs_address_in(avs_address_in),
		.avs_read_in(avs_read_in),
		.avs_write_in(avs_write_in),
		.avs_writedata_in(avs_writedata_in),
		.avs_byteenable_in(avs_byteenable_in),
		.avs_readdata_out(avs_readdata_out),
		.avs_waitrequest_out(avs_waitrequest_out),
		.event_in(event_in),
		.irq_out(irq_out),
		.module_on_out(module_on_out)
	);

	// ************************************************************
	// Shared tasks
	// ************************************************************
	task finish_test;
		$display("checks=%0d failures=%0d", check_count, failures);
		if (failures == 0 && check_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : finish_test

	task check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			failures++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	// Request stays up until waitrequest is sampled low
	task wait_ack;
		int n;
		n = 0;
		do begin
			@(posedge clk_in);
			n++;
		end while (avs_waitrequest_out !== 1'b0 && n < 20);
		if (avs_waitrequest_out !== 1'b0) begin
			failures++;
			finish_test();
		end
	endtask : wait_ack

	task wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
		avs_address_in <= a;
		avs_writedata_in <= d;
		avs_byteenable_in <= be;
		avs_write_in <= 1'b1;
		wait_ack();
		avs_write_in <= 1'b0;
		@(posedge clk_in);
	endtask : wr

	task rd(input logic [3:0] a, output logic [31:0] q);
		avs_address_in <= a;
		avs_read_in <= 1'b1;
		wait_ack();
		q = avs_readdata_out;
		avs_read_in <= 1'b0;
		@(posedge clk_in);
	endtask : rd

	task pulse(input int i);
		event_in <= 9'(9'h001 << i);
		@(posedge clk_in);
		event_in <= 9'h000;
		repeat (2) @(posedge clk_in);
	endtask : pulse

	// ************************************************************
	// Scenarios
	// ************************************************************
	task test_reset;
		logic [31:0] q;
		reset_in <= 1'b1;
		repeat (6) @(posedge clk_in);
		reset_in <= 1'b0;
		@(posedge clk_in);
		check(32'(irq_out), 32'h0);
		check(32'(module_on_out), 32'h0);
		rd(4'h0, q);
		check(q, 32'h0000_0000);
		rd(4'h4, q);
		check(q, 32'h0000_0000);
	endtask : test_reset

	task test_lanes;
		logic [31:0] q;
		wr(4'h0, 32'hffff_ffff, 4'h8);
		rd(4'h0, q);
		check(q, 32'hf800_0000);
		wr(4'h0, 32'hffff_ffff, 4'hf);
		wr(4'h8, 32'hffff_ffff, 4'hf);
		rd(4'h8, q);
		check(q, 32'h0000_0000);
		rd(4'h0, q);
		check(q, 32'hf80f_0000);
		wr(4'h0, 32'h0000_0000, 4'hf);
	endtask : test_lanes

	task test_sources;
		logic [31:0] q;
		logic [31:0] others;
		int i;
		wr(4'h4, 32'h0000_8000, 4'hf);
		check(32'(module_on_out), 32'h1);
		for (int k = 0; k < 9; k++) begin
			i = ord[k];
			// Every other enable set, so a swapped gate shows up
			others = 32'hf80f_0000 & ~(32'h1 << epos[i]);
			wr(4'h0, others, 4'hf);
			pulse(i);
			rd(4'h0, q);
			check(q, others | (32'h1 << fpos[i]));
			check(32'(irq_out), 32'h0);
			wr(4'h0, (32'h1 << epos[i]) | (32'h1 << fpos[i]), 4'hf);
			check(32'(irq_out), 32'h1);
			wr(4'h0, 32'h0000_0000, 4'hf);
			rd(4'h0, q);
			check(q, (i == 5) ? 32'h0000_1000 : 32'h0000_0000);
			check(32'(irq_out), 32'h0);
		end
	endtask : test_sources

	task test_sys_err_clear;
		logic [31:0] q;
		wr(4'h0, 32'h1000_0000, 4'hf);
		check(32'(irq_out), 32'h1);
		wr(4'h4, 32'h0000_0000, 4'hf);
		rd(4'h0, q);
		check(q, 32'h1000_1000);
		wr(4'h4, 32'h0000_8000, 4'hf);
		rd(4'h0, q);
		check(q, 32'h1000_0000);
		check(32'(irq_out), 32'h0);
	endtask : test_sys_err_clear

	initial begin
		test_reset();
		test_lanes();
		test_sources();
		test_sys_err_clear();
		test_reset();
		finish_test();
	end
endmodule : tb
